/* design/etic_params.svh */
// Register offsets, field positions, reset values and timing for the interrupt block.
// Assumes inclusion by its bare name from the design module, the checker and the bench.
`ifndef ETIC_PARAMS_SVH
`define ETIC_PARAMS_SVH

`define ETIC_OFF_TFLAG 12'h038
`define ETIC_OFF_GMASK 12'h040
`define ETIC_OFF_GFLAG 12'h044
`define ETIC_OFF_TMASK 12'h048
`define ETIC_OFF_MCUCTRL 12'h04c
`define ETIC_OFF_KPSENSE 12'h050
`define ETIC_OFF_STATUS 12'h054
`define ETIC_OFF_VECTOR 12'h058

`define ETIC_BIT_PIN_B 7
`define ETIC_BIT_SUSP 6
`define ETIC_BIT_T16_OVF 7
`define ETIC_BIT_T16_CMPA 6
`define ETIC_BIT_T16_CMPB 5
`define ETIC_BIT_T16_CAPT 3
`define ETIC_BIT_T8_OVF 1
`define ETIC_BIT_GIE 7
`define ETIC_SENSE_HI 3
`define ETIC_SENSE_LO 2
`define ETIC_KP_FLAG_HI 11
`define ETIC_KP_FLAG_LO 8

`define ETIC_GEN_VALID 8'hc0
`define ETIC_TMR_VALID 8'hea
`define ETIC_RST_8 8'h00
`define ETIC_RST_32 32'h0000_0000
`define ETIC_PIN_IDLE 5'h1f

`define ETIC_VEC_NONE 16'h0000
`define ETIC_VEC_SUSP 16'h0002
`define ETIC_VEC_PIN_B 16'h0004
`define ETIC_VEC_T16_CAPT 16'h0006
`define ETIC_VEC_T16_CMPA 16'h0008
`define ETIC_VEC_T16_CMPB 16'h000a
`define ETIC_VEC_T16_OVF 16'h000c
`define ETIC_VEC_T8_OVF 16'h000e

`define ETIC_RESP_CYCLES 3'h4
`define ETIC_CNT_ONE 3'h1

`endif

/* design/etic_pkg.sv */
// Types shared by the interrupt block and its bench.
// Assumes etic_params.svh on the include path.
package etic_pkg;

typedef enum logic [1:0] {
    ETIC_SENSE_LOW = 2'b00,
    ETIC_SENSE_RSVD = 2'b01,
    ETIC_SENSE_FALL = 2'b10,
    ETIC_SENSE_RISE = 2'b11
} etic_sense_t;

typedef enum logic [1:0] {
    ETIC_ST_IDLE = 2'b00,
    ETIC_ST_WAIT = 2'b01,
    ETIC_ST_REQ = 2'b10
} etic_state_t;

typedef struct packed {
    logic t16_ovf;
    logic t16_cmpa;
    logic t16_cmpb;
    logic t16_capt;
    logic t8_ovf;
} etic_tmr_ev_t;

typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
} etic_apb_req_t;

endpackage

/* design/etic_irq_ctrl.sv */
// Interrupt flag/mask controller: pins, suspend/resume and timer events to a vectored request.
// Assumes one 200 MHz clock, a synchronous active-low reset and an APB master on the same clock.
`include "etic_params.svh"

// Functional notes
// - Pin request needs its enable and global enable
// - Sense field picks rise, fall or low
// - Pin detected even when driven as output
// - Suspend request gated by enable, global, vector 2
// - General registers bits 5..0 read zero
// - Pin event sets flag bit 7, vector 4
// - Suspend event sets flag bit 6
// - General flags clear on entry or write-one
// - T16 overflow request needs enable, global, flag
// - Compare A/B requests need enable, global, flag
// - Capture request needs enable, global, flag
// - T8 overflow request needs enable, global, flag
// - Timer registers bits 4,2,0 read zero
// - T16 overflow or PWM reversal sets flag
// - Compare matches set compare flags
// - Capture event sets capture flag
// - T8 overflow sets its flag
// - Timer flags clear on vector or write-one
// - Low level retriggers while pin low
// - Pin plus four keypad pins, configurable sense
// - Entry clears global enable; return sets it
// - Flags hold while disabled; level unlatched
// - Sense codes 00 low, 10 fall, 11 rise
// - Vector request four cycles after flag
module etic_irq_ctrl
    import etic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic pin_irq_b_i,
    input wire logic [3:0] keypad_irq_pins_i,
    input wire logic susp_resume_irq_i,
    input wire logic t16_ovf_i,
    input wire logic t16_pwm_bottom_i,
    input wire logic t16_cmpa_i,
    input wire logic t16_cmpb_i,
    input wire logic t16_capt_i,
    input wire logic t8_ovf_i,
    input wire logic irq_ack_i,
    input wire logic irq_return_instr_i,
    output logic irq_req_o,
    output logic [15:0] irq_vector_o,
    output logic global_irq_en_o,
    output logic [3:0] keypad_flags_o
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
// The pin input is read from the pad, so a pin driven as output by the port still reaches here.
logic [4:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r;
always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        pin_s1_r <= `ETIC_PIN_IDLE;
        pin_s2_r <= `ETIC_PIN_IDLE;
        pin_s3_r <= `ETIC_PIN_IDLE;
        pin_lvl_r <= `ETIC_PIN_IDLE;
    end else begin
        pin_s1_r <= {keypad_irq_pins_i, pin_irq_b_i};
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
        for (int i = 0; i < 5; i++) begin
            if (pin_s2_r[i] == pin_s3_r[i]) begin
                pin_lvl_r[i] <= pin_s3_r[i];
            end
        end
    end
end

logic susp_s1_r, susp_s2_r, susp_s3_r, susp_lvl_r;
always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        susp_s1_r <= 1'b0;
        susp_s2_r <= 1'b0;
        susp_s3_r <= 1'b0;
        susp_lvl_r <= 1'b0;
    end else begin
        susp_s1_r <= susp_resume_irq_i;
        susp_s2_r <= susp_s1_r;
        susp_s3_r <= susp_s2_r;
        if (susp_s2_r == susp_s3_r) begin
            susp_lvl_r <= susp_s3_r;
        end
    end
end

// ----------------------------------------------------------------
// Registers and APB decode
// ----------------------------------------------------------------
logic [7:0] gen_mask_r, gen_flag_r, tmr_mask_r, tmr_flag_r, mcu_ctrl_r, kp_sense_r;
logic [3:0] kp_flag_r;
logic [4:0] lvl_prev_r;
logic gie_r;
logic [7:0] gen_flag_nxt, tmr_flag_nxt;
logic [3:0] kp_flag_nxt;
logic [4:0] edge_hit;
logic wr_en, rd_en;
logic [7:0] wbyte;

assign wr_en = psel_i && penable_i && pwrite_i;
assign rd_en = psel_i && penable_i && !pwrite_i;
assign wbyte = pwdata_i[7:0];

// Edge or level event per pin, using a two-bit sense code for each
function automatic logic sense_hit(input logic [1:0] code, input logic prev, input logic cur);
    etic_sense_t s;
    s = etic_sense_t'(code);
    unique case (s)
        ETIC_SENSE_LOW: sense_hit = !cur;
        ETIC_SENSE_FALL: sense_hit = prev && !cur;
        ETIC_SENSE_RISE: sense_hit = !prev && cur;
        ETIC_SENSE_RSVD: sense_hit = 1'b0;
    endcase
endfunction

always_comb begin
    edge_hit[0] = sense_hit(mcu_ctrl_r[`ETIC_SENSE_HI:`ETIC_SENSE_LO], lvl_prev_r[0], pin_lvl_r[0]);
    for (int k = 0; k < 4; k++) begin
        edge_hit[k+1] = sense_hit(kp_sense_r[2*k+:2], lvl_prev_r[k+1], pin_lvl_r[k+1]);
    end
end

always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        lvl_prev_r <= `ETIC_PIN_IDLE;
    end else begin
        lvl_prev_r <= pin_lvl_r;
    end
end

logic susp_prev_r;
always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        susp_prev_r <= 1'b0;
    end else begin
        susp_prev_r <= susp_lvl_r;
    end
end

logic pin_level_mode, pin_level_req;
assign pin_level_mode = mcu_ctrl_r[`ETIC_SENSE_HI:`ETIC_SENSE_LO] == ETIC_SENSE_LOW;
// Level mode is not latched: request lasts only while the pin is low
assign pin_level_req = pin_level_mode && !pin_lvl_r[0];

logic [15:0] ack_vec;
logic take;
assign take = irq_ack_i && irq_req_o;
assign ack_vec = take ? irq_vector_o : `ETIC_VEC_NONE;

// ----------------------------------------------------------------
// Flag update
// ----------------------------------------------------------------
// Set wins over clear; a zero written leaves a flag alone
always_comb begin
    gen_flag_nxt = gen_flag_r;
    tmr_flag_nxt = tmr_flag_r;
    kp_flag_nxt = kp_flag_r;
    if (wr_en && paddr_i == `ETIC_OFF_GFLAG) begin
        gen_flag_nxt = gen_flag_nxt & ~(wbyte & `ETIC_GEN_VALID);
    end
    if (wr_en && paddr_i == `ETIC_OFF_TFLAG) begin
        tmr_flag_nxt = tmr_flag_nxt & ~(wbyte & `ETIC_TMR_VALID);
    end
    if (wr_en && paddr_i == `ETIC_OFF_KPSENSE) begin
        kp_flag_nxt = kp_flag_nxt & ~pwdata_i[`ETIC_KP_FLAG_HI:`ETIC_KP_FLAG_LO];
    end
    if (ack_vec == `ETIC_VEC_PIN_B) gen_flag_nxt[`ETIC_BIT_PIN_B] = 1'b0;
    if (ack_vec == `ETIC_VEC_SUSP) gen_flag_nxt[`ETIC_BIT_SUSP] = 1'b0;
    if (ack_vec == `ETIC_VEC_T16_OVF) tmr_flag_nxt[`ETIC_BIT_T16_OVF] = 1'b0;
    if (ack_vec == `ETIC_VEC_T16_CMPA) tmr_flag_nxt[`ETIC_BIT_T16_CMPA] = 1'b0;
    if (ack_vec == `ETIC_VEC_T16_CMPB) tmr_flag_nxt[`ETIC_BIT_T16_CMPB] = 1'b0;
    if (ack_vec == `ETIC_VEC_T16_CAPT) tmr_flag_nxt[`ETIC_BIT_T16_CAPT] = 1'b0;
    if (ack_vec == `ETIC_VEC_T8_OVF) tmr_flag_nxt[`ETIC_BIT_T8_OVF] = 1'b0;
    if (edge_hit[0] && !pin_level_mode) gen_flag_nxt[`ETIC_BIT_PIN_B] = 1'b1;
    if (susp_lvl_r && !susp_prev_r) gen_flag_nxt[`ETIC_BIT_SUSP] = 1'b1;
    if (t16_ovf_i || t16_pwm_bottom_i) tmr_flag_nxt[`ETIC_BIT_T16_OVF] = 1'b1;
    if (t16_cmpa_i) tmr_flag_nxt[`ETIC_BIT_T16_CMPA] = 1'b1;
    if (t16_cmpb_i) tmr_flag_nxt[`ETIC_BIT_T16_CMPB] = 1'b1;
    if (t16_capt_i) tmr_flag_nxt[`ETIC_BIT_T16_CAPT] = 1'b1;
    if (t8_ovf_i) tmr_flag_nxt[`ETIC_BIT_T8_OVF] = 1'b1;
    kp_flag_nxt = kp_flag_nxt | edge_hit[4:1];
end

always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        gen_flag_r <= `ETIC_RST_8;
        tmr_flag_r <= `ETIC_RST_8;
        kp_flag_r <= 4'h0;
    end else begin
        gen_flag_r <= gen_flag_nxt & `ETIC_GEN_VALID;
        tmr_flag_r <= tmr_flag_nxt & `ETIC_TMR_VALID;
        kp_flag_r <= kp_flag_nxt;
    end
end

// ----------------------------------------------------------------
// Mask and control registers
// ----------------------------------------------------------------
always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        gen_mask_r <= `ETIC_RST_8;
        tmr_mask_r <= `ETIC_RST_8;
        mcu_ctrl_r <= `ETIC_RST_8;
        kp_sense_r <= `ETIC_RST_8;
    end else if (wr_en) begin
        if (paddr_i == `ETIC_OFF_GMASK) gen_mask_r <= wbyte & `ETIC_GEN_VALID;
        if (paddr_i == `ETIC_OFF_TMASK) tmr_mask_r <= wbyte & `ETIC_TMR_VALID;
        if (paddr_i == `ETIC_OFF_MCUCTRL) mcu_ctrl_r <= wbyte;
        if (paddr_i == `ETIC_OFF_KPSENSE) kp_sense_r <= wbyte;
    end
end

// ----------------------------------------------------------------
// Global enable
// ----------------------------------------------------------------
// Global enable: cleared on entry, set by return or software
always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        gie_r <= 1'b0;
    end else if (take) begin
        gie_r <= 1'b0;
    end else if (irq_return_instr_i) begin
        gie_r <= 1'b1;
    end else if (wr_en && paddr_i == `ETIC_OFF_STATUS) begin
        gie_r <= wbyte[`ETIC_BIT_GIE];
    end
end

// ----------------------------------------------------------------
// Priority and vector request
// ----------------------------------------------------------------
logic [15:0] pick_vec;
logic pick_any;
always_comb begin
    pick_vec = `ETIC_VEC_NONE;
    pick_any = 1'b0;
    if (gie_r) begin
        // Checked from highest vector to lowest so the lowest address is left standing
        if (tmr_mask_r[`ETIC_BIT_T8_OVF] && tmr_flag_r[`ETIC_BIT_T8_OVF]) begin
            pick_vec = `ETIC_VEC_T8_OVF;
            pick_any = 1'b1;
        end
        if (tmr_mask_r[`ETIC_BIT_T16_OVF] && tmr_flag_r[`ETIC_BIT_T16_OVF]) begin
            pick_vec = `ETIC_VEC_T16_OVF;
            pick_any = 1'b1;
        end
        if (tmr_mask_r[`ETIC_BIT_T16_CMPB] && tmr_flag_r[`ETIC_BIT_T16_CMPB]) begin
            pick_vec = `ETIC_VEC_T16_CMPB;
            pick_any = 1'b1;
        end
        if (tmr_mask_r[`ETIC_BIT_T16_CMPA] && tmr_flag_r[`ETIC_BIT_T16_CMPA]) begin
            pick_vec = `ETIC_VEC_T16_CMPA;
            pick_any = 1'b1;
        end
        if (tmr_mask_r[`ETIC_BIT_T16_CAPT] && tmr_flag_r[`ETIC_BIT_T16_CAPT]) begin
            pick_vec = `ETIC_VEC_T16_CAPT;
            pick_any = 1'b1;
        end
        if (gen_mask_r[`ETIC_BIT_PIN_B] && (gen_flag_r[`ETIC_BIT_PIN_B] || pin_level_req)) begin
            pick_vec = `ETIC_VEC_PIN_B;
            pick_any = 1'b1;
        end
        if (gen_mask_r[`ETIC_BIT_SUSP] && gen_flag_r[`ETIC_BIT_SUSP]) begin
            pick_vec = `ETIC_VEC_SUSP;
            pick_any = 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Response delay
// ----------------------------------------------------------------
// Response delay: request goes out four cycles after a pending source appears
etic_state_t state_r;
logic [2:0] wait_cnt_r;
always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        state_r <= ETIC_ST_IDLE;
        wait_cnt_r <= 3'h0;
        irq_req_o <= 1'b0;
        irq_vector_o <= `ETIC_VEC_NONE;
    end else begin
        unique case (state_r)
            ETIC_ST_IDLE: begin
                irq_req_o <= 1'b0;
                if (pick_any) begin
                    state_r <= ETIC_ST_WAIT;
                    wait_cnt_r <= `ETIC_RESP_CYCLES - `ETIC_CNT_ONE;
                end
            end
            ETIC_ST_WAIT: begin
                if (!pick_any) begin
                    state_r <= ETIC_ST_IDLE;
                end else if (wait_cnt_r == `ETIC_CNT_ONE) begin
                    state_r <= ETIC_ST_REQ;
                    irq_req_o <= 1'b1;
                    irq_vector_o <= pick_vec;
                end else begin
                    wait_cnt_r <= wait_cnt_r - `ETIC_CNT_ONE;
                end
            end
            ETIC_ST_REQ: begin
                // Vector is re-evaluated each cycle so a lower address arriving late still wins
                if (take || !pick_any) begin
                    state_r <= ETIC_ST_IDLE;
                    irq_req_o <= 1'b0;
                end else begin
                    irq_vector_o <= pick_vec;
                end
            end
            default: begin
                state_r <= ETIC_ST_IDLE;
                irq_req_o <= 1'b0;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// APB answer
// ----------------------------------------------------------------
always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        prdata_o <= `ETIC_RST_32;
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
    end else begin
        pready_o <= psel_i && !penable_i;
        pslverr_o <= 1'b0;
        if (psel_i && !penable_i) begin
            prdata_o <= `ETIC_RST_32;
            unique case (paddr_i)
                `ETIC_OFF_GMASK: prdata_o[7:0] <= gen_mask_r & `ETIC_GEN_VALID;
                `ETIC_OFF_GFLAG: prdata_o[7:0] <= gen_flag_r & `ETIC_GEN_VALID;
                `ETIC_OFF_TMASK: prdata_o[7:0] <= tmr_mask_r & `ETIC_TMR_VALID;
                `ETIC_OFF_TFLAG: prdata_o[7:0] <= tmr_flag_r & `ETIC_TMR_VALID;
                `ETIC_OFF_MCUCTRL: prdata_o[7:0] <= mcu_ctrl_r;
                `ETIC_OFF_KPSENSE: prdata_o[`ETIC_KP_FLAG_HI:0] <= {kp_flag_r, kp_sense_r};
                `ETIC_OFF_STATUS: prdata_o[`ETIC_BIT_GIE] <= gie_r;
                `ETIC_OFF_VECTOR: prdata_o[16:0] <= {irq_req_o, irq_vector_o};
                default: pslverr_o <= 1'b1;
            endcase
        end
    end
end

always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
        global_irq_en_o <= 1'b0;
        keypad_flags_o <= 4'h0;
    end else begin
        global_irq_en_o <= gie_r;
        keypad_flags_o <= kp_flag_r;
    end
end

endmodule

/* sim/etic_core_model.sv */
// Core stand-in that takes vectored requests after a chosen delay.
// Assumes the block's clock and reset; the bench issues the return itself.
module etic_core_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic irq_req_i,
    input wire logic [15:0] irq_vector_i,
    input wire logic [3:0] delay_i,
    output logic irq_ack_o,
    output logic [15:0] taken_vec_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r;
    // Ack is one cycle wide and only while the request stands
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !irq_req_i || irq_ack_o) begin
            wait_r <= 4'h0;
            irq_ack_o <= 1'b0;
        end else if (wait_r == delay_i) begin
            irq_ack_o <= 1'b1;
            taken_vec_o <= irq_vector_i;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule

/* sim/etic_irq_ctrl_chk.sv */
// Port-level assertions for the interrupt block.
// Assumes it is bound onto etic_irq_ctrl and sees only its ports.
`include "etic_params.svh"
module etic_irq_ctrl_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_ack_i,
    input wire logic irq_return_instr_i,
    input wire logic irq_req_o,
    input wire logic [15:0] irq_vector_o,
    input wire logic global_irq_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // --------------------------------
    // Bus and interrupt checks
    // --------------------------------
    apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    refused_zero_a: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
        else $error("refused access returned data");
    gen_rsvd_a: assert property (
        pready_o && (paddr_i == `ETIC_OFF_GMASK || paddr_i == `ETIC_OFF_GFLAG)
        |-> (prdata_o & ~{24'h0, `ETIC_GEN_VALID}) == 32'h0) else $error("general reserved bits set");
    tmr_rsvd_a: assert property (
        pready_o && (paddr_i == `ETIC_OFF_TMASK || paddr_i == `ETIC_OFF_TFLAG)
        |-> (prdata_o & ~{24'h0, `ETIC_TMR_VALID}) == 32'h0) else $error("timer reserved bits set");
    ack_drop_a: assert property (
        irq_req_o && irq_ack_i |=> !irq_req_o) else $error("request stands after ack");
    // Guards keep a same-edge return or status write out of the way
    gie_clear_a: assert property (
        irq_req_o && irq_ack_i && !irq_return_instr_i && !penable_i |=> ##1 !global_irq_en_o)
        else $error("global enable kept on entry");
    gie_ret_a: assert property (
        irq_return_instr_i && !irq_ack_i && !penable_i |-> ##2 global_irq_en_o)
        else $error("return did not set global enable");
    no_gie_a: assert property (
        !global_irq_en_o [*3] |-> !irq_req_o) else $error("request without global enable");
    vec_legal_a: assert property (
        irq_req_o |-> !irq_vector_o[0] && irq_vector_o inside {[`ETIC_VEC_SUSP:`ETIC_VEC_T8_OVF]})
        else $error("illegal vector");
    cover property (irq_req_o && irq_ack_i);
    cover property (pready_o && pslverr_o);
    cover property (irq_return_instr_i ##2 global_irq_en_o);
endmodule

bind etic_irq_ctrl etic_irq_ctrl_chk etic_irq_ctrl_chk_inst (.clk_i, .rst_n_i, .psel_i, .penable_i, .paddr_i,
    .prdata_o, .pready_o, .pslverr_o, .irq_ack_i, .irq_return_instr_i, .irq_req_o, .irq_vector_o, .global_irq_en_o);

/* sim/etic_irq_ctrl_tb_top.sv */
// Self-checking bench for the interrupt block with a core stand-in.
// Assumes the design, the checker and the core model compiled first.
`include "etic_params.svh"
module etic_irq_ctrl_tb_top
    import etic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    etic_apb_req_t apb_req = '0;
    etic_tmr_ev_t ev = '0;
    logic pin = 1'b1, susp = 1'b0, ret = 1'b0, pwm = 1'b0, pready, pslverr, req, gie, ack, err;
    logic [3:0] kp = 4'hf, dly = 4'h0, kpf;
    logic [15:0] vec, taken;
    logic [31:0] prdata;
    int fail_count = 0;
    int comparisons = 0;
    always #2.5 clk_i = ~clk_i;
    etic_irq_ctrl etic_irq_ctrl_inst (.clk_i, .rst_n_i, .psel_i(apb_req.psel), .penable_i(apb_req.penable),
        .pwrite_i(apb_req.pwrite), .paddr_i(apb_req.paddr), .pwdata_i(apb_req.pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pin_irq_b_i(pin), .keypad_irq_pins_i(kp),
        .susp_resume_irq_i(susp), .t16_ovf_i(ev.t16_ovf), .t16_pwm_bottom_i(pwm), .t16_cmpa_i(ev.t16_cmpa),
        .t16_cmpb_i(ev.t16_cmpb), .t16_capt_i(ev.t16_capt), .t8_ovf_i(ev.t8_ovf), .irq_ack_i(ack),
        .irq_return_instr_i(ret), .irq_req_o(req), .irq_vector_o(vec), .global_irq_en_o(gie),
        .keypad_flags_o(kpf));
    etic_core_model etic_core_model_inst (.clk_i, .rst_n_i, .irq_req_i(req), .irq_vector_i(vec),
        .delay_i(dly), .irq_ack_o(ack), .taken_vec_o(taken));
    // --------------------------------
    // Helpers
    // --------------------------------
    function automatic logic [7:0] tmr_bits(input etic_tmr_ev_t e);
        return {e.t16_ovf, e.t16_cmpa, e.t16_cmpb, 1'b0, e.t16_capt, 1'b0, e.t8_ovf, 1'b0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_i);
        apb_req.penable <= 1'b1;
        // Waits for the answer however long; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1);
        chk(n, 1);
        q = prdata;
        err = pslverr;
        // An idle cycle between transfers keeps one assignment per time step
        apb_req <= '0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [11:0] d);
        logic [31:0] q;
        apb_xfer(1'b1, a, {20'h0, d}, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb_xfer(1'b0, a, $urandom, q);
        chk(q, e);
    endtask
    task automatic pulse(input etic_tmr_ev_t e);
        ev <= e;
        @(posedge clk_i);
        ev <= '0;
        @(posedge clk_i);
    endtask
    task automatic sense(input logic [11:0] m, input logic p, input logic [31:0] e);
        wr(`ETIC_OFF_MCUCTRL, m);
        pin <= p;
        repeat (8) @(posedge clk_i);
        rd(`ETIC_OFF_GFLAG, e);
        wr(`ETIC_OFF_GFLAG, 12'h080);
    endtask
    task automatic serve(input logic [15:0] e);
        int n;
        n = 0;
        while (ack !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        chk(taken, e);
        ret <= 1'b1;
        @(posedge clk_i);
        ret <= 1'b0;
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #50us;
        fail_count++;
        end_of_test();
    end
    // --------------------------------
    // Scenarios
    // --------------------------------
    initial begin
        etic_tmr_ev_t r;
        logic [7:0] d;
        int n;
        void'($urandom(32'h16d9));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(`ETIC_OFF_TFLAG, 32'h0);
        rd(`ETIC_OFF_GFLAG, 32'h0);
        rd(`ETIC_OFF_VECTOR, 32'h0);
        wr(`ETIC_OFF_GMASK, 12'h0ff);
        wr(`ETIC_OFF_TMASK, 12'h0ff);
        rd(`ETIC_OFF_GMASK, 32'hc0);
        rd(`ETIC_OFF_TMASK, 32'hea);
        rd(12'hffc, 32'h0);
        chk(err, 1'b1);
        // Global enable is still off, so flags must simply collect
        repeat (8) begin
            r = etic_tmr_ev_t'($urandom);
            d = 8'($urandom);
            pulse(r);
            rd(`ETIC_OFF_TFLAG, {24'h0, tmr_bits(r)});
            wr(`ETIC_OFF_TFLAG, {4'h0, d});
            rd(`ETIC_OFF_TFLAG, {24'h0, tmr_bits(r) & ~d});
            wr(`ETIC_OFF_TFLAG, 12'h0ff);
        end
        pwm <= 1'b1;
        @(posedge clk_i);
        pwm <= 1'b0;
        rd(`ETIC_OFF_TFLAG, 32'h80);
        wr(`ETIC_OFF_TFLAG, 12'h0ff);
        sense(12'h008, 1'b0, 32'h80);
        sense(12'h00c, 1'b1, 32'h80);
        sense(12'h004, 1'b0, 32'h0);
        sense(12'h004, 1'b1, 32'h0);
        susp <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd(`ETIC_OFF_GFLAG, 32'h40);
        wr(`ETIC_OFF_KPSENSE, 12'h0aa);
        kp <= 4'h0;
        repeat (8) @(posedge clk_i);
        chk(kpf, 4'hf);
        wr(`ETIC_OFF_KPSENSE, 12'hfaa);
        @(posedge clk_i);
        chk(kpf, 4'h0);
        wr(`ETIC_OFF_MCUCTRL, 12'h008);
        pin <= 1'b0;
        pulse(5'h1f);
        dly <= 4'($urandom % 8);
        repeat (8) @(posedge clk_i);
        wr(`ETIC_OFF_STATUS, 12'h080);
        rd(`ETIC_OFF_STATUS, 32'h80);
        chk(gie, 1'b1);
        for (int i = 1; i < 8; i++) serve(16'(2 * i));
        rd(`ETIC_OFF_TFLAG, 32'h0);
        rd(`ETIC_OFF_GFLAG, 32'h0);
        wr(`ETIC_OFF_MCUCTRL, 12'h000);
        serve(16'h0004);
        serve(16'h0004);
        pin <= 1'b1;
        repeat (12) @(posedge clk_i);
        rd(`ETIC_OFF_GFLAG, 32'h0);
        wr(`ETIC_OFF_STATUS, 12'h080);
        ev.t8_ovf <= 1'b1;
        n = 0;
        while (req !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            ev <= '0;
            n++;
        end
        chk(n, 6);
        serve(16'h000e);
        rd(`ETIC_OFF_TFLAG, 32'h0);
        end_of_test();
    end
endmodule
